// file: rtl/fcs_pkg.sv
// constants and carrier types for the serial frame check value engine
// assumes one 50 MHz clock and bit-serial framing logic upstream
package fcs_pkg;
   localparam int          CRC_WIDTH     = 32;
   localparam int          INVERT_BITS   = 32;
   localparam int          FIFO_DEPTH    = 32;
   localparam int          CLK_PERIOD_NS = 20;
   // generator terms below x^32: 0,1,2,4,5,7,8,10,11,12,16,22,23,26
   localparam logic [31:0] GEN_POLY      = 32'h04C1_1DB7;
   localparam logic [31:0] CRC_RESET     = 32'h0000_0000;
   localparam logic [31:0] ALL_ONES      = 32'hFFFF_FFFF;
   localparam logic [5:0]  COUNT_RESET   = 6'h00;
   localparam logic [5:0]  INVERT_LIMIT  = 6'h20;

   // one frame bit with its framing marks
   typedef struct packed {
      logic start;
      logic last;
      logic data;
   } frame_bit_type;

   typedef enum logic [1:0] {
      IDLE,
      RUN,
      DONE
   } crc_state_type;
endpackage

// file: rtl/frame_check_seq_crc32.sv
// bit fifo and serial frame check value engine
// assumes framing logic presents one bit per valid/ready handshake, msb first
// How it works
// - leading thirty-two frame bits enter inverted
// - shorter frames have all bits inverted
// - first frame bit is highest coefficient
// - serial division register computes remainder
// - remainder inverted gives the check value
// - fixed degree-32 generator polynomial used
// - check value optional; caller may omit it
`timescale 1ns/10ps

module bit_fifo #(
   parameter int WIDTH = 3,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      fill;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (fill != (AW+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else begin
         if (push) wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
         if (pop)  rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
         fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) mem[wr_ptr] <= in_data;
   end

   // occupancy and pointer bookkeeping
   a_fill_bound: assert property (@(posedge clk_sys) disable iff (rst)
      fill <= (AW+1)'(DEPTH))
      else $error("fifo fill above depth");
   a_ptr_gap: assert property (@(posedge clk_sys) disable iff (rst)
      wr_ptr == AW'(rd_ptr + fill))
      else $error("fifo pointers disagree with fill");
   a_fill_push: assert property (@(posedge clk_sys) disable iff (rst)
      (push && !pop) |=> fill == $past(fill) + (AW+1)'(1))
      else $error("fifo push not counted");
   a_fill_pop: assert property (@(posedge clk_sys) disable iff (rst)
      (pop && !push) |=> fill == $past(fill) - (AW+1)'(1))
      else $error("fifo pop not counted");
   a_fifo_reset: assert property (@(posedge clk_sys)
      rst |=> fill == '0)
      else $error("fifo not empty after reset");
endmodule

module frame_check_seq_crc32
   import fcs_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire logic          bit_valid,
   output      logic          bit_ready,
   input  wire frame_bit_type bit_in,
   input  wire logic [31:0]   received_value,
   output      logic [31:0]   frame_check_value,
   output      logic          value_valid,
   output      logic          value_match
);
   crc_state_type state;
   frame_bit_type fbit;
   logic          f_valid;
   logic [31:0]   crc;
   logic [5:0]    count;
   logic [31:0]   next_crc;
   logic [31:0]   next_value;

   bit_fifo #(.WIDTH($bits(frame_bit_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (bit_valid),
      .in_ready  (bit_ready),
      .in_data   (bit_in),
      .out_valid (f_valid),
      .out_ready (1'b1),
      .out_data  (fbit)
   );

   wire         take      = f_valid;
   wire         restart   = take && fbit.start;
   wire [31:0]  base      = restart ? CRC_RESET : crc;
   wire [5:0]   base_cnt  = restart ? COUNT_RESET : count;
   wire         invert    = (base_cnt < INVERT_LIMIT);
   wire         eff_bit   = fbit.data ^ invert;
   wire         feedback  = base[31] ^ eff_bit;
   assign next_crc   = {base[30:0], 1'b0} ^ (feedback ? GEN_POLY : CRC_RESET);
   assign next_value = next_crc ^ ALL_ONES;
   wire         accept    = take && (restart || state == RUN);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state             <= IDLE;
         crc               <= CRC_RESET;
         count             <= COUNT_RESET;
         frame_check_value <= CRC_RESET;
         value_valid       <= 1'b0;
         value_match       <= 1'b0;
      end else begin
         value_valid <= 1'b0;
         if (accept) begin
            crc   <= next_crc;
            count <= invert ? base_cnt + 6'h01 : base_cnt;
            state <= fbit.last ? DONE : RUN;
            if (fbit.last) begin
               frame_check_value <= next_value;
               value_valid       <= 1'b1;
               value_match       <= (next_value == received_value);
            end
         end else if (state == DONE) begin
            state <= IDLE;
         end
      end
   end

   // value always produced; a caller that omits it ignores it

   a_valid_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      value_valid |=> !value_valid || $past(accept && fbit.last))
      else $error("valid not tied to frame end");
   a_valid_cause: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && fbit.last) |=> value_valid)
      else $error("frame end without result");
   a_value_inverted: assert property (@(posedge clk_sys) disable iff (rst)
      value_valid |-> frame_check_value == (crc ^ ALL_ONES))
      else $error("check value not inverted remainder");
   a_invert_lead: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && base_cnt < INVERT_LIMIT) |-> eff_bit == !fbit.data)
      else $error("leading bit not inverted");
   a_pass_after: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && base_cnt == INVERT_LIMIT) |-> eff_bit == fbit.data)
      else $error("later bit altered");
   a_count_cap: assert property (@(posedge clk_sys) disable iff (rst)
      count <= INVERT_LIMIT)
      else $error("inversion count overran");
   a_restart_clear: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && fbit.start) |=> count == 6'h01)
      else $error("restart did not clear count");
   a_shift_poly: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && !fbit.start && !feedback) |=> crc == {$past(crc[30:0]), 1'b0})
      else $error("division register shift wrong");
   a_poly_xor: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && !fbit.start && feedback) |=>
         crc == ({$past(crc[30:0]), 1'b0} ^ GEN_POLY))
      else $error("generator not applied");
   a_match_flag: assert property (@(posedge clk_sys) disable iff (rst)
      value_valid |-> value_match == (frame_check_value == $past(received_value)))
      else $error("match flag wrong");

   // frame control and result holding
   a_crc_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !accept |=> crc == $past(crc) && count == $past(count))
      else $error("division register moved without a bit");
   a_idle_drop: assert property (@(posedge clk_sys) disable iff (rst)
      (take && !restart && state != RUN) |=> state != RUN)
      else $error("bit without start opened a frame");
   a_idle_silent: assert property (@(posedge clk_sys) disable iff (rst)
      (take && !restart && state != RUN) |=> !value_valid)
      else $error("dropped bit produced a result");
   a_value_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !value_valid |-> $stable(frame_check_value) && $stable(value_match))
      else $error("result changed between frame ends");
   a_count_step: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && !restart && count < INVERT_LIMIT) |=> count == $past(count) + 6'h01)
      else $error("inversion count did not advance");
   a_invert_stop: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && base_cnt >= INVERT_LIMIT) |=> count == INVERT_LIMIT)
      else $error("inversion count moved after lead");
   a_first_feedback: assert property (@(posedge clk_sys) disable iff (rst)
      restart |-> feedback == !fbit.data)
      else $error("first bit not inverted into cleared register");
   a_restart_seed: assert property (@(posedge clk_sys) disable iff (rst)
      restart |=> crc == ($past(feedback) ? GEN_POLY : CRC_RESET))
      else $error("restart did not seed division register");
   a_result_state: assert property (@(posedge clk_sys) disable iff (rst)
      value_valid |-> state == DONE)
      else $error("result outside frame end");
   a_done_return: assert property (@(posedge clk_sys) disable iff (rst)
      (state == DONE && !accept) |=> state == IDLE)
      else $error("engine stuck after frame end");
   a_ready_high: assert property (@(posedge clk_sys) disable iff (rst)
      bit_ready)
      else $error("input refused although fifo drains");
   a_reset_idle: assert property (@(posedge clk_sys)
      rst |=> state == IDLE && !value_valid && count == COUNT_RESET)
      else $error("reset did not clear engine");

   c_long_frame: cover property (@(posedge clk_sys) disable iff (rst)
      accept && fbit.last && base_cnt == INVERT_LIMIT);
   c_short_frame: cover property (@(posedge clk_sys) disable iff (rst)
      accept && fbit.last && base_cnt < INVERT_LIMIT);
   c_match: cover property (@(posedge clk_sys) disable iff (rst) value_valid && value_match);
   c_fifo_full: cover property (@(posedge clk_sys) disable iff (rst) !bit_ready);
   c_restart_mid: cover property (@(posedge clk_sys) disable iff (rst)
      take && fbit.start && state == RUN);
endmodule

// file: sim/frame_source.sv
// framing logic model: offers frame bits msb first, one per handshake
// assumes inputs of the engine are sampled on the rising clock edge
`timescale 1ns/10ps
module frame_source
   import fcs_pkg::*;
(
   input  wire logic    clk_sys,
   input  wire logic    bit_ready,
   output      logic          bit_valid,
   output      frame_bit_type bit_in
);
   initial begin
      bit_valid = 1'b0;
      bit_in    = '0;
   end
   // start marked at index rs (none if negative), last at n-1
   task automatic send(input logic [63:0] d, input int n, input int rs);
      for (int i = 0; i < n; i++) begin
         @(negedge clk_sys);
         bit_valid <= 1'b1;
         bit_in    <= '{start: (i == rs), last: (i == n - 1), data: d[n-1-i]};
         @(posedge clk_sys);
         while (!bit_ready) @(posedge clk_sys);
      end
      @(negedge clk_sys);
      bit_valid   <= 1'b0;
      bit_in.data <= ~bit_in.data;
   endtask
   // start at index 0 and no last mark: leaves a frame running
   task automatic send_open(input logic [63:0] d, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk_sys);
         bit_valid <= 1'b1;
         bit_in    <= '{start: (i == 0), last: 1'b0, data: d[n-1-i]};
         @(posedge clk_sys);
         while (!bit_ready) @(posedge clk_sys);
      end
      @(negedge clk_sys);
      bit_valid <= 1'b0;
   endtask
endmodule

// file: sim/test_frame_check_seq_crc32.sv
// bench for the serial frame check value engine
// assumes the engine answers one cycle after the last bit is taken
`timescale 1ns/10ps
module test_frame_check_seq_crc32
   import fcs_pkg::*;
;
   logic          clk_sys;
   logic          rst;
   logic          bit_valid;
   logic          bit_ready;
   frame_bit_type bit_in;
   logic [31:0]   received_value;
   logic [31:0]   frame_check_value;
   logic          value_valid;
   logic          value_match;
   int            errors;
   int            checks_done;
   int            cycles;
   logic [31:0]   held_value;
   logic          held_match;

   frame_check_seq_crc32 u_dut (.clk_sys(clk_sys), .rst(rst), .bit_valid(bit_valid),
      .bit_ready(bit_ready), .bit_in(bit_in), .received_value(received_value),
      .frame_check_value(frame_check_value), .value_valid(value_valid),
      .value_match(value_match));
   frame_source u_src (.clk_sys(clk_sys), .bit_ready(bit_ready), .bit_valid(bit_valid),
      .bit_in(bit_in));

   initial begin
      clk_sys = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
   end

   task automatic summarize();
      if (errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // long division of the frame, leading 32 bits complemented, followed by 32 zero bits
   function automatic logic [31:0] exp_crc(input logic [63:0] d, input int n, input int rs);
      logic [31:0] r;
      logic        top;
      logic        b;
      r = 32'h0000_0000;
      for (int k = 0; k < n - rs + CRC_WIDTH; k++) begin
         b   = (k < n - rs) ? (d[n-1-rs-k] ^ (k < INVERT_BITS)) : 1'b0;
         top = r[31];
         r   = {r[30:0], b} ^ (top ? GEN_POLY : 32'h0000_0000);
      end
      return ~r;
   endfunction

   // one frame; good selects a matching or a corrupted received value
   task automatic run(input logic [63:0] d, input int n, input int rs, input logic good);
      logic [31:0] e;
      e = exp_crc(d, n, rs);
      received_value = good ? e : ~e;
      u_src.send(d, n, rs);
      @(posedge clk_sys);
      @(negedge clk_sys);
      compare({31'h0, value_valid}, {31'h0, rs >= 0});
      if (rs >= 0) begin
         held_value = e;
         held_match = good;
      end
      compare(frame_check_value, held_value);
      compare({31'h0, value_match}, {31'h0, held_match});
      @(negedge clk_sys);
      compare({31'h0, value_valid}, 32'h0000_0000);
   endtask

   task automatic short_frames();
      run(64'h0000_0000_0000_00A5, 8, 0, 1'b1);
      run(64'h0000_0000_0000_0001, 1, 0, 1'b0);
   endtask

   task automatic long_frames();
      run(64'h0000_00C3_1234_5678, 40, 0, 1'b0);
      run(64'h8000_0000_0000_0000, 64, 0, 1'b1);
      run(64'hDEAD_BEEF_0F0F_1357, 64, 0, 1'b1);
   endtask

   // bits ahead of the start mark, and a frame with no start, are dropped
   task automatic late_start();
      run(64'h0000_ABCD_5555_3333, 48, 16, 1'b1);
      run(64'h0000_0000_0000_00FF, 8, -1, 1'b1);
   endtask

   // a start mark inside a running frame begins a new one
   task automatic restart_mid();
      u_src.send_open(64'h0000_0000_0000_0F0F, 12);
      compare({31'h0, value_valid}, 32'h0000_0000);
      run(64'h0000_0000_1357_9BDF, 32, 0, 1'b1);
   endtask

   // reset in mid frame clears the result and the open frame
   task automatic reset_mid();
      u_src.send_open(64'h0000_0000_0000_3C3C, 16);
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      compare(frame_check_value, 32'h0000_0000);
      compare({30'h0, value_valid, value_match}, 32'h0000_0000);
      rst = 1'b0;
      held_value = 32'h0000_0000;
      held_match = 1'b0;
      compare({31'h0, bit_ready}, 32'h0000_0001);
      run(64'h0000_0000_0000_0055, 7, 0, 1'b1);
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end

   initial begin
      rst = 1'b1;
      received_value = 32'h0000_0000;
      errors = 0;
      checks_done = 0;
      cycles = 0;
      held_value = 32'h0000_0000;
      held_match = 1'b0;
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      compare({31'h0, bit_ready}, 32'h0000_0001);
      short_frames();
      long_frames();
      late_start();
      restart_mid();
      reset_mid();
      summarize();
   end
endmodule
